/* File: rtl/fsps_device.sv */
// Function
// - store disabled unless fuse programmed zero
// - software erases page before writing it
// - buffer loads accepted before or after erase
// - buffer words loadable in any order
// - pattern 03 then store erases page
// - erase uses only the page field
// - cpu halted for whole erase
// - pattern 01 then store loads word
// - buffer cleared after write or clear bit
// - buffer cleared on every reset
// - each word loaded once between clears
// - eeprom write discards loaded buffer data
// - pattern 05 then store writes page
// - cpu halted for whole write
// - pointer splits into word and page
// - load instruction reads bytes via bit zero
// - erase and write use same page
// - eeprom write blocks all flash programming
// - software checks eeprom busy before control write
// - command bits clear on completion or timeout
// - erase and write last 3.7 to 4.5 ms
`timescale 1ns/1ps
module fsps_device #(
    parameter int WORD_BITS = 5,
    parameter int PAGE_BITS = 4,
    parameter int PROG_CYCLES = fsps_pkg::PROG_MIN_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    fsps_if.dev link,
    input wire logic self_program_fuse,
    input wire logic eeprom_write_busy,
    output logic op_done
);
    localparam int WORDS = 1 << WORD_BITS;
    localparam int MEM_AW = WORD_BITS + PAGE_BITS;
    localparam int MEM_WORDS = 1 << MEM_AW;

    fsps_pkg::fsps_state_t state;
    logic [2:0] cmd;
    logic [2:0] win;
    logic [PAGE_BITS-1:0] page_lat;
    logic [15:0] page_buf [WORDS];
    logic [WORDS-1:0] loaded;
    logic [15:0] flash [MEM_WORDS];
    logic ee_q;
    logic fuse_ok;
    logic csr_take;
    logic store_hit;
    logic do_erase;
    logic do_load;
    logic do_write;
    logic ee_rise;
    logic buf_clear;
    logic timer_done;
    logic finish;
    logic [WORD_BITS-1:0] load_word;
    logic [15:0] rd_word;

    // word field sits above the byte select bit
    function automatic logic [WORD_BITS-1:0] word_of(input logic [15:0] z);
        word_of = z[WORD_BITS:1];
    endfunction : word_of

    // page field sits above the word field
    function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] z);
        page_of = z[MEM_AW:WORD_BITS+1];
    endfunction : page_of

    assign fuse_ok = (self_program_fuse == fsps_pkg::FUSE_PROGRAMMED);
    // control writes dropped while eeprom busy
    assign csr_take = link.csr_we && !eeprom_write_busy
                      && (state == fsps_pkg::FSPS_IDLE);
    // store outside armed window is ignored
    assign store_hit = link.store_program_instr && (win != 3'h0)
                       && cmd[fsps_pkg::CSR_STORE_EN]
                       && fuse_ok && !eeprom_write_busy
                       && (state == fsps_pkg::FSPS_IDLE);
    assign do_erase = store_hit
        && ({fsps_pkg::CSR_UPPER_ZERO, cmd} == fsps_pkg::PAT_ERASE);
    assign do_load = store_hit
        && ({fsps_pkg::CSR_UPPER_ZERO, cmd} == fsps_pkg::PAT_LOAD);
    assign do_write = store_hit
        && ({fsps_pkg::CSR_UPPER_ZERO, cmd} == fsps_pkg::PAT_WRITE);
    assign finish = timer_done && (state != fsps_pkg::FSPS_IDLE);
    assign load_word = word_of(link.z);

    assign ee_rise = eeprom_write_busy && !ee_q;
    // clear bit, finished write, or eeprom start
    assign buf_clear = (csr_take && link.csr_wdata[fsps_pkg::CSR_CLEAR_BUF])
        || ee_rise || (finish && (state == fsps_pkg::FSPS_WRITE));

    always_ff @(posedge clk) begin
        if (rst) begin
            ee_q <= 1'b0;
        end else begin
            ee_q <= eeprom_write_busy;
        end
    end

    // command bits and four-cycle arm window
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd <= 3'h0;
            win <= 3'h0;
        end else if (csr_take) begin
            cmd <= link.csr_wdata[fsps_pkg::CSR_WRITE:fsps_pkg::CSR_STORE_EN];
            // every accepted write opens the window, so stray bits expire
            win <= fsps_pkg::ARM_CYCLES;
        end else if (store_hit) begin
            win <= 3'h0;
            // erase and write bits stay up until the operation ends
            if (!do_erase && !do_write) begin
                cmd <= 3'h0;
            end
        end else if (finish) begin
            cmd <= 3'h0;
        end else if (win == 3'h1) begin
            cmd <= 3'h0;
            win <= 3'h0;
        end else if (win != 3'h0) begin
            win <= win - 3'h1;
        end
    end

    // sequencer holds the cpu while busy
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= fsps_pkg::FSPS_IDLE;
            page_lat <= '0;
        end else begin
            case (state)
                fsps_pkg::FSPS_IDLE: begin
                    if (do_erase) begin
                        state <= fsps_pkg::FSPS_ERASE;
                        page_lat <= page_of(link.z);
                    end else if (do_write) begin
                        state <= fsps_pkg::FSPS_WRITE;
                        page_lat <= page_of(link.z);
                    end
                end
                fsps_pkg::FSPS_ERASE, fsps_pkg::FSPS_WRITE: begin
                    if (timer_done) begin
                        state <= fsps_pkg::FSPS_IDLE;
                    end
                end
                default: begin
                    state <= fsps_pkg::FSPS_IDLE;
                end
            endcase
        end
    end

    fsps_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .start(do_erase || do_write),
        .done(timer_done)
    );

    // loaded mask cleared by reset and clears
    always_ff @(posedge clk) begin
        if (rst) begin
            loaded <= '0;
        end else if (buf_clear) begin
            loaded <= '0;
        end else if (do_load) begin
            loaded[load_word] <= 1'b1;
        end
    end

    // a reload before clearing keeps the first data
    always_ff @(posedge clk) begin
        if (do_load && !buf_clear && !loaded[load_word]) begin
            page_buf[load_word] <= link.data_pair;
        end
    end

    // programming can only clear bits, as in real flash cells
    always_ff @(posedge clk) begin
        if (finish) begin
            for (int i = 0; i < WORDS; i++) begin
                if (state == fsps_pkg::FSPS_ERASE) begin
                    flash[{page_lat, WORD_BITS'(i)}] <= fsps_pkg::ERASED_WORD;
                end else begin
                    flash[{page_lat, WORD_BITS'(i)}] <=
                        flash[{page_lat, WORD_BITS'(i)}]
                        & (loaded[i] ? page_buf[i] : fsps_pkg::ERASED_WORD);
                end
            end
        end
    end

    assign rd_word = flash[link.z[MEM_AW:1]];

    // byte read, bit zero picks high byte
    always_ff @(posedge clk) begin
        if (rst) begin
            link.rd_byte_valid <= 1'b0;
            link.rd_byte <= 8'h00;
        end else begin
            link.rd_byte_valid <= link.load_program_instr
                                  && (state == fsps_pkg::FSPS_IDLE);
            if (link.load_program_instr
                && (state == fsps_pkg::FSPS_IDLE)) begin
                link.rd_byte <= link.z[0] ? rd_word[15:8] : rd_word[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op_done <= 1'b0;
        end else begin
            op_done <= finish;
        end
    end

    assign link.halt = (state != fsps_pkg::FSPS_IDLE);
    assign link.csr_rdata = {fsps_pkg::CSR_UPPER_ZERO, cmd};
endmodule : fsps_device

/* File: rtl/fsps_pkg.sv */
package fsps_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int CSR_W = 8;

    // control/status bit positions
    localparam int CSR_STORE_EN = 0;
    localparam int CSR_ERASE = 1;
    localparam int CSR_WRITE = 2;
    localparam int CSR_CLEAR_BUF = 4;

    // command patterns written to the control register
    localparam logic [7:0] PAT_ERASE = 8'h03;
    localparam logic [7:0] PAT_LOAD = 8'h01;
    localparam logic [7:0] PAT_WRITE = 8'h05;
    localparam logic [4:0] CSR_UPPER_ZERO = 5'h00;

    localparam logic [2:0] ARM_CYCLES = 3'h4;
    localparam logic FUSE_PROGRAMMED = 1'b0;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    localparam int CLK_PERIOD_NS = 40;
    localparam int PROG_MIN_NS = 3700000;
    localparam int PROG_MAX_NS = 4500000;
    localparam int PROG_MIN_CYCLES =
        (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_PERIOD_NS;

    // host APB register map
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_POINTER = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam int CMD_CSR_BIT = 8;
    localparam int CMD_STORE_BIT = 9;
    localparam int CMD_READ_BIT = 10;
    localparam int ST_HALT_BIT = 8;
    localparam int ST_BUSY_BIT = 9;
    localparam int ST_EE_BIT = 10;
    localparam int ST_BYTE_LSB = 16;

    typedef enum logic [1:0] {
        FSPS_IDLE,
        FSPS_ERASE,
        FSPS_WRITE
    } fsps_state_t;

    typedef enum logic [1:0] {
        FSPS_H_IDLE,
        FSPS_H_CSR,
        FSPS_H_ISSUE,
        FSPS_H_WAIT
    } fsps_hstate_t;
endpackage : fsps_pkg

/* File: rtl/fsps_if.sv */
`timescale 1ns/1ps
interface fsps_if;
    logic csr_we;
    logic [7:0] csr_wdata;
    logic [7:0] csr_rdata;
    logic store_program_instr;
    logic load_program_instr;
    logic [15:0] z;
    logic [15:0] data_pair;
    logic [7:0] rd_byte;
    logic rd_byte_valid;
    logic halt;

    modport dev (
        input csr_we,
        input csr_wdata,
        input store_program_instr,
        input load_program_instr,
        input z,
        input data_pair,
        output csr_rdata,
        output rd_byte,
        output rd_byte_valid,
        output halt
    );

    modport host (
        output csr_we,
        output csr_wdata,
        output store_program_instr,
        output load_program_instr,
        output z,
        output data_pair,
        input csr_rdata,
        input rd_byte,
        input rd_byte_valid,
        input halt
    );
endinterface : fsps_if

/* File: rtl/fsps_prog_timer.sv */
`timescale 1ns/1ps
module fsps_prog_timer #(
    parameter int CYCLES = fsps_pkg::PROG_MIN_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count;

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else if (start) begin
            count <= CW'(CYCLES);
        end else if (count != '0) begin
            count <= count - CW'(1);
        end
    end

    // done in the last of CYCLES busy cycles
    assign done = (count == CW'(1));
endmodule : fsps_prog_timer

/* File: rtl/fsps_host.sv */
`timescale 1ns/1ps
module fsps_host (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    fsps_if.host link,
    input wire logic eeprom_write_busy
);
    fsps_pkg::fsps_hstate_t state;
    logic [15:0] pointer;
    logic [15:0] data_pair;
    logic [7:0] csr_val;
    logic flag_store;
    logic flag_read;
    logic [7:0] last_byte;
    logic access;
    logic mapped;
    logic cmd_wr;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == fsps_pkg::REG_CMD) || (a == fsps_pkg::REG_POINTER)
                    || (a == fsps_pkg::REG_DATA)
                    || (a == fsps_pkg::REG_STATUS);
    endfunction : is_mapped

    assign mapped = is_mapped(paddr);
    // a new command waits until the previous one has finished
    assign pready = !(psel && penable && pwrite
                      && (paddr == fsps_pkg::REG_CMD)
                      && (state != fsps_pkg::FSPS_H_IDLE));
    assign access = psel && penable && pready;
    assign pslverr = psel && penable && !mapped;
    assign cmd_wr = access && pwrite && (paddr == fsps_pkg::REG_CMD);

    always_ff @(posedge clk) begin
        if (rst) begin
            pointer <= 16'h0000;
            data_pair <= 16'h0000;
        end else if (access && pwrite) begin
            if (paddr == fsps_pkg::REG_POINTER) begin
                pointer <= pwdata[15:0];
            end
            if (paddr == fsps_pkg::REG_DATA) begin
                data_pair <= pwdata[15:0];
            end
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata <= 32'h00000000;
            case (paddr)
                fsps_pkg::REG_POINTER: prdata[15:0] <= pointer;
                fsps_pkg::REG_DATA: prdata[15:0] <= data_pair;
                fsps_pkg::REG_STATUS: begin
                    prdata[7:0] <= link.csr_rdata;
                    prdata[fsps_pkg::ST_HALT_BIT] <= link.halt;
                    prdata[fsps_pkg::ST_BUSY_BIT] <=
                        (state != fsps_pkg::FSPS_H_IDLE);
                    prdata[fsps_pkg::ST_EE_BIT] <= eeprom_write_busy;
                    prdata[fsps_pkg::ST_BYTE_LSB+:8] <= last_byte;
                end
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            csr_val <= 8'h00;
            flag_store <= 1'b0;
            flag_read <= 1'b0;
        end else if (cmd_wr) begin
            csr_val <= pwdata[7:0];
            flag_store <= pwdata[fsps_pkg::CMD_STORE_BIT];
            flag_read <= pwdata[fsps_pkg::CMD_READ_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= fsps_pkg::FSPS_H_IDLE;
        end else begin
            case (state)
                fsps_pkg::FSPS_H_IDLE: begin
                    if (cmd_wr && pwdata[fsps_pkg::CMD_CSR_BIT]) begin
                        state <= fsps_pkg::FSPS_H_CSR;
                    end else if (cmd_wr && (pwdata[fsps_pkg::CMD_STORE_BIT]
                                 || pwdata[fsps_pkg::CMD_READ_BIT])) begin
                        state <= fsps_pkg::FSPS_H_ISSUE;
                    end
                end
                fsps_pkg::FSPS_H_CSR: begin
                    // hold the control write while eeprom busy
                    if (!eeprom_write_busy) begin
                        state <= (flag_store || flag_read)
                                 ? fsps_pkg::FSPS_H_ISSUE
                                 : fsps_pkg::FSPS_H_IDLE;
                    end
                end
                fsps_pkg::FSPS_H_ISSUE: begin
                    state <= fsps_pkg::FSPS_H_WAIT;
                end
                fsps_pkg::FSPS_H_WAIT: begin
                    if (!link.halt) begin
                        state <= fsps_pkg::FSPS_H_IDLE;
                    end
                end
                default: begin
                    state <= fsps_pkg::FSPS_H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            last_byte <= 8'h00;
        end else if (link.rd_byte_valid) begin
            last_byte <= link.rd_byte;
        end
    end

    assign link.csr_we = (state == fsps_pkg::FSPS_H_CSR) && !eeprom_write_busy;
    assign link.csr_wdata = csr_val;
    // store issued the cycle after the control write
    assign link.store_program_instr = (state == fsps_pkg::FSPS_H_ISSUE)
                                      && flag_store;
    assign link.load_program_instr = (state == fsps_pkg::FSPS_H_ISSUE)
                                     && flag_read && !flag_store;
    assign link.z = pointer;
    assign link.data_pair = data_pair;
endmodule : fsps_host

/* File: tb/fsps_chk.sv */
`timescale 1ns/1ps
module fsps_chk #(
    parameter int PROG_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic csr_we,
    input wire logic [7:0] csr_wdata,
    input wire logic [7:0] csr_rdata,
    input wire logic store_program_instr,
    input wire logic load_program_instr,
    input wire logic rd_byte_valid,
    input wire logic halt,
    input wire logic self_program_fuse,
    input wire logic eeprom_write_busy
);
    logic [31:0] halt_cnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // counts halted cycles so the full length is checked on the fall
    always_ff @(posedge clk) begin
        if (rst || !halt) begin
            halt_cnt <= 32'h0;
        end else begin
            halt_cnt <= halt_cnt + 32'h1;
        end
    end

    a_halt_length: assert property (
        $fell(halt) |-> halt_cnt == PROG_CYCLES)
        else $error("halt length differs from programming time");
    a_start_armed: assert property (
        $rose(halt)
        |-> $past(store_program_instr && csr_rdata[2:1] != 2'b00))
        else $error("operation started without armed store");
    a_fuse_blocks: assert property (
        store_program_instr && self_program_fuse |=> !halt)
        else $error("store ran with fuse unprogrammed");
    a_eeprom_blocks: assert property (
        $rose(halt) |-> !$past(eeprom_write_busy))
        else $error("flash operation started during eeprom write");
    a_cmd_latch: assert property (
        csr_we && !halt && csr_wdata[2:1] != 2'b00
        |=> csr_rdata[2:0] == $past(csr_wdata[2:0]))
        else $error("command bits not latched");
    a_cmd_expire: assert property (
        csr_we && !halt ##1 !store_program_instr [*4]
        |=> csr_rdata[2:0] == 3'h0)
        else $error("command bits kept after four idle cycles");
    a_cmd_hold: assert property (
        halt |-> csr_rdata[2:1] != 2'b00)
        else $error("command bit cleared while operation runs");
    a_read_answer: assert property (
        load_program_instr && !halt |=> rd_byte_valid)
        else $error("byte read gave no answer");
    a_read_cause: assert property (
        rd_byte_valid |-> $past(load_program_instr))
        else $error("byte answer without request");
    a_load_no_halt: assert property (
        store_program_instr && csr_rdata[2:0] == 3'h1 |=> !halt)
        else $error("buffer load halted the core");
endmodule : fsps_chk

/* File: tb/fsps_tb.sv */
`timescale 1ns/1ps
module fsps_tb;
    localparam int PROG = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fuse = 1'b0;
    logic ee_busy = 1'b0;
    logic op_done;
    int mismatches = 0;
    int n_tests = 0;
    int n_done = 0;
    logic [31:0] r;
    logic e;

    fsps_if link();
    fsps_host fsps_host_inst(.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link),
        .eeprom_write_busy(ee_busy));
    fsps_device #(.WORD_BITS(5), .PAGE_BITS(4), .PROG_CYCLES(PROG))
        fsps_device_inst(.clk(clk), .rst(rst), .link(link),
        .self_program_fuse(fuse), .eeprom_write_busy(ee_busy),
        .op_done(op_done));
    fsps_chk #(.PROG_CYCLES(PROG)) fsps_chk_inst(.clk(clk), .rst(rst),
        .csr_we(link.csr_we), .csr_wdata(link.csr_wdata),
        .csr_rdata(link.csr_rdata),
        .store_program_instr(link.store_program_instr),
        .load_program_instr(link.load_program_instr),
        .rd_byte_valid(link.rd_byte_valid), .halt(link.halt),
        .self_program_fuse(fuse), .eeprom_write_busy(ee_busy));

    always #20 clk = ~clk;

    // one completion pulse per finished erase or write
    always @(posedge clk) begin
        if (op_done === 1'b1) begin
            n_done <= n_done + 1;
        end
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // wait for the answer, bounded
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 1000);
        if (pready !== 1'b1) begin
            mismatches++;
            close_out();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic stat();
        apb(1'b0, fsps_pkg::REG_STATUS, 32'h0);
    endtask : stat

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            stat();
            n++;
        end while (r[9:8] !== 2'h0 && n < 100);
        if (n >= 100) begin
            mismatches++;
            close_out();
        end
    endtask : wait_idle

    task automatic hpoll(input logic exp);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 8; i++) begin
            stat();
            if (r[8] === 1'b1) begin
                seen = 1'b1;
            end
        end
        check({31'h0, seen}, {31'h0, exp});
        wait_idle();
    endtask : hpoll

    // junk outside the page field on erase must not matter
    task automatic go(input logic [7:0] pat, input logic [3:0] pg,
                      input logic exp);
        logic [15:0] z;
        z = {6'h00, pg, 6'h00};
        if (pat == fsps_pkg::PAT_ERASE) begin
            z = z | 16'hFC3F;
        end
        apb(1'b1, fsps_pkg::REG_POINTER, {16'h0, z});
        apb(1'b1, fsps_pkg::REG_CMD, {24'h000003, pat});
        hpoll(exp);
    endtask : go

    task automatic load(input logic [3:0] pg, input logic [4:0] w,
                        input logic [15:0] d);
        apb(1'b1, fsps_pkg::REG_POINTER, {22'h0, pg, w, 1'b0});
        apb(1'b1, fsps_pkg::REG_DATA, {16'h0, d});
        apb(1'b1, fsps_pkg::REG_CMD, 32'h00000301);
    endtask : load

    task automatic rdw(input logic [3:0] pg, input logic [4:0] w,
                       input logic [15:0] exp);
        for (int b = 0; b < 2; b++) begin
            apb(1'b1, fsps_pkg::REG_POINTER, {22'h0, pg, w, b[0]});
            apb(1'b1, fsps_pkg::REG_CMD, 32'h00000400);
            wait_idle();
            stat();
            check({24'h0, r[23:16]}, {24'h0, exp[8*b +: 8]});
        end
    endtask : rdw

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        stat();
        check(r, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check({r[30:0], e}, 32'h1);
        go(fsps_pkg::PAT_ERASE, 4'h2, 1'b1);
        rdw(4'h2, 5'h03, 16'hFFFF);
        load(4'h2, 5'h03, 16'hA55A);
        load(4'h2, 5'h01, 16'h0F0F);
        load(4'h2, 5'h03, 16'h1234);
        go(fsps_pkg::PAT_WRITE, 4'h2, 1'b1);
        rdw(4'h2, 5'h03, 16'hA55A);
        rdw(4'h2, 5'h01, 16'h0F0F);
        rdw(4'h2, 5'h00, 16'hFFFF);
        load(4'h4, 5'h02, 16'hBEEF);
        go(fsps_pkg::PAT_ERASE, 4'h4, 1'b1);
        go(fsps_pkg::PAT_WRITE, 4'h4, 1'b1);
        rdw(4'h4, 5'h02, 16'hBEEF);
        go(fsps_pkg::PAT_ERASE, 4'h3, 1'b1);
        go(fsps_pkg::PAT_WRITE, 4'h3, 1'b1);
        rdw(4'h3, 5'h02, 16'hFFFF);
        load(4'h5, 5'h02, 16'h1234);
        apb(1'b1, fsps_pkg::REG_CMD, 32'h00000110);
        go(fsps_pkg::PAT_ERASE, 4'h5, 1'b1);
        go(fsps_pkg::PAT_WRITE, 4'h5, 1'b1);
        rdw(4'h5, 5'h02, 16'hFFFF);
        go(fsps_pkg::PAT_ERASE, 4'h6, 1'b1);
        load(4'h6, 5'h04, 16'h5A5A);
        // let the store land first, so the eeprom start hits a full buffer
        repeat (2) @(posedge clk);
        ee_busy <= 1'b1;
        stat();
        check({31'h0, r[10]}, 32'h1);
        ee_busy <= 1'b0;
        go(fsps_pkg::PAT_WRITE, 4'h6, 1'b1);
        rdw(4'h6, 5'h04, 16'hFFFF);
        fuse <= 1'b1;
        go(fsps_pkg::PAT_ERASE, 4'h2, 1'b0);
        fuse <= 1'b0;
        rdw(4'h2, 5'h03, 16'hA55A);
        apb(1'b1, fsps_pkg::REG_CMD, 32'h00000105);
        repeat (6) @(posedge clk);
        stat();
        check({24'h0, r[7:0]}, 32'h0);
        apb(1'b1, fsps_pkg::REG_CMD, 32'h00000200);
        hpoll(1'b0);
        load(4'h7, 5'h01, 16'h0000);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        go(fsps_pkg::PAT_ERASE, 4'h7, 1'b1);
        go(fsps_pkg::PAT_WRITE, 4'h7, 1'b1);
        rdw(4'h7, 5'h01, 16'hFFFF);
        check(n_done, 32'h0000000C);
        close_out();
    end
endmodule : fsps_tb
